/* File: rtl/bil_consts.svh */
// constants of the boot image loader: offsets, header layout, jumper fields
// assumes inclusion by bil_loader.sv only; bil_pkg.sv does not include it
`ifndef BIL_CONSTS_SVH
`define BIL_CONSTS_SVH

// ----------------------------------------
// register offsets on the register port
// ----------------------------------------
`define BIL_OFS_BANK 12'h800
`define BIL_OFS_JMP 12'h801
`define BIL_OFS_PD 12'h802
`define BIL_OFS_STAT 12'h803

// ----------------------------------------
// image header layout (longword index)
// ----------------------------------------
`define BIL_PAT0 32'h5a5ac3c3
`define BIL_PAT1 32'ha5a53c3c
`define BIL_HW_HSIZE 4'h2
`define BIL_HW_ICSUM 4'h3
`define BIL_HW_ISIZE 4'h4
`define BIL_HW_DFLAG 4'h5
`define BIL_HW_DLO 4'h6
`define BIL_HW_DHI 4'h7
`define BIL_HW_REV 4'h8
`define BIL_HW_FSIZE 4'h9
`define BIL_HW_HCSUM 4'hc
`define BIL_HDR_WORDS 4'hd
`define BIL_HDR_V0 32'h00000020

// ----------------------------------------
// boot memory, clock ram, jumpers
// ----------------------------------------
`define BIL_MEM_BYTES 21'h100000
`define BIL_CRAM_SEL_ADDR 6'h3f
`define BIL_JMP_BOOT_OPT 7
`define BIL_JMP_DEBUG 6
`define BIL_SYNC_CYCLES 2'h2
`define BIL_WORD_BYTES 3'h4

`endif

/* File: rtl/bil_loader.sv */
// boot image loader: image search, header checks, load stream, bank select
// assumes one clock, a same-clock boot memory and clock ram read port,
// and jumper pins that arrive asynchronously
//
// Behaviour
// - boot memory is two 512KB halves; lower half mapped after reset.
// - writing 1 to bank register 0x800 drives memory address bit 19 high outside header read and load.
// - upper half stays selected until reset or a 0 is written.
// - header found only on 5a5ac3c3 followed by a5a53c3c.
// - parse size, checksums, sizes, flag, destination, revision, header checksum.
// - image body starts at header start plus header size; extra content ignored.
// - a header size of 32 bytes means header format version 0.
// - image size bounds how many bytes are loaded.
// - decompression flag set expands repeating-byte runs, else plain copy.
// - image written at the 64-bit header destination, execution handed there.
// - firmware type is revision bits 15:8, header revision bits 7:0.
// - image checksum verifies the stored image bytes read from boot memory.
// - no header means whole 1MB loaded and run at address zero.
// - boot-select jumper out (reads 1) loads the first image unless the debug-trap jumper is fitted.
// - jumper fitted reads clock ram byte 0x3f to pick the image.
// - codes 00, 01, 02/03 select firmware types 0, 1, 2.
// - code 8n loads the nth image; n zero means the whole memory.
// - image not found loads first valid; none valid loads whole memory at 0.
// - presence-detect and configuration jumpers captured at reset, readable.
// - fitted debug-trap jumper (bit 6) diverts to the serial debug port.
// - cache period bits 5:3 decode to 6/8/10/12/15 ns, others reserved.
// - cache size bits 2:0 decode off/512KB/1MB/2MB/4MB/8MB, others reserved.
`timescale 1ns/10ps
`default_nettype none
`include "bil_consts.svh"

// ----------------------------------------
// byte fifo between decompressor and load stream
// ----------------------------------------
module bil_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [0:D-1];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic wr_en;
	logic rd_en;

	assign wr_en = in_valid && in_ready;
	assign rd_en = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	// flags registered from the next count so both sides see flops
	always_comb begin
		next_count = count;
		if (wr_en && !rd_en) begin
			next_count = count + 1'b1;
		end else if (rd_en && !wr_en) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (wr_en) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (rd_en) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= next_count;
			in_ready <= next_count != (AW+1)'(D);
			out_valid <= next_count != '0;
		end
	end

	// storage has no reset; only written words are ever read
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

// ----------------------------------------
// loader top
// ----------------------------------------
module bil_loader import bil_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// boot memory read port
	output logic mem_rd,
	output logic [18:0] mem_addr,
	output logic mem_a19,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_rvalid,
	// clock-backed ram read port
	output logic cbr_rd,
	output logic [5:0] cbr_addr,
	input wire logic [7:0] cbr_rdata,
	input wire logic cbr_rvalid,
	// jumper pins
	input wire logic [7:0] soft_config_bit,
	input wire logic [7:0] presence_detect,
	// load stream
	output logic load_valid,
	output logic [63:0] load_addr,
	output logic [7:0] load_byte,
	input wire logic load_ready,
	// status
	output logic boot_done,
	output logic [63:0] exec_addr,
	output logic debug_trap,
	output logic checksum_ok,
	output logic [7:0] fw_type,
	output logic [4:0] cache_period_ns,
	output logic [13:0] cache_size_kb,
	output logic cache_cfg_reserved
);
	bil_state_t state;
	bil_want_t want_kind;
	logic [7:0] want_val;
	logic [1:0] cap_cnt;
	logic [7:0] jmp_s1, jmp_s2, pd_s1, pd_s2, soft_cfg, pd_cfg;
	logic bank_sel, rd_pend, cbr_pend, have_first, force_take, whole_mem, decomp;
	logic [19:0] base, first_base, rd_addr;
	logic [7:0] idx;
	logic [3:0] hw_idx;
	logic [31:0] hdr [0:12];
	logic [31:0] img_csum, img_size, csum_acc, out_rem, push_cnt;
	logic [63:0] tgt;
	logic [20:0] in_rem;
	logic [31:0] wbuf;
	logic [2:0] wcnt;
	logic [7:0] lit_cnt, rep_cnt, rep_len, rep_byte;
	logic rep_pend;
	logic fifo_in_ready, push, take;
	logic [7:0] pdata;
	logic pat_ok, v0, hdr_ok, eval_whole, eval_take, sel_hit;
	logic [31:0] hsum, stored;
	logic [32:0] nb;
	logic [63:0] dest;

	// selection code to {kind, value}; unknown codes ask for firmware type ff
	function automatic logic [9:0] sel_decode(input logic [7:0] code);
		if (code == 8'h00 || code == 8'h01) begin
			sel_decode = {WANT_TYPE, code};
		end else if (code == 8'h02 || code == 8'h03) begin
			sel_decode = {WANT_TYPE, 8'h02};
		end else if (code[7:4] == 4'h8) begin
			sel_decode = (code[3:0] == 4'h0) ? {WANT_WHOLE, 8'h00} : {WANT_INDEX, 4'h0, code[3:0]};
		end else begin
			sel_decode = {WANT_TYPE, 8'hff};
		end
	endfunction

	function automatic logic [4:0] period_ns(input logic [2:0] code);
		unique case (code)
			3'h1: period_ns = 5'h06;
			3'h2: period_ns = 5'h08;
			3'h3: period_ns = 5'h0a;
			3'h4: period_ns = 5'h0c;
			3'h5: period_ns = 5'h0f;
			default: period_ns = 5'h00;
		endcase
	endfunction

	function automatic logic [13:0] size_kb(input logic [2:0] code);
		size_kb = (code == 3'h0 || code > 3'h5) ? 14'h0000 : 14'(14'h0100 << code);
	endfunction

	// ----------------------------------------
	// jumper capture and decode
	// ----------------------------------------
	// two flops before anything reads the pins
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			{jmp_s1, jmp_s2, pd_s1, pd_s2} <= '0;
		end else begin
			jmp_s1 <= soft_config_bit;
			jmp_s2 <= jmp_s1;
			pd_s1 <= presence_detect;
			pd_s2 <= pd_s1;
		end
	end

	// levels latched once the synchroniser has filled after release
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			soft_cfg <= 8'hff;
			pd_cfg <= 8'h00;
			cache_period_ns <= 5'h00;
			cache_size_kb <= 14'h0000;
			cache_cfg_reserved <= 1'b0;
		end else begin
			if (state == ST_CAPT && cap_cnt == `BIL_SYNC_CYCLES) begin
				soft_cfg <= jmp_s2;
				pd_cfg <= pd_s2;
			end
			cache_period_ns <= period_ns(soft_cfg[5:3]);
			cache_size_kb <= size_kb(soft_cfg[2:0]);
			cache_cfg_reserved <= period_ns(soft_cfg[5:3]) == 5'h00 || soft_cfg[2:0] > 3'h5;
		end
	end

	// ----------------------------------------
	// register port
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			bank_sel <= 1'b0;
			reg_rdata <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == `BIL_OFS_BANK) begin
				bank_sel <= reg_wdata[0];
			end
			// bank register is write-only and reads zero
			if (reg_rd) begin
				unique case (reg_addr)
					`BIL_OFS_JMP: reg_rdata <= soft_cfg;
					`BIL_OFS_PD: reg_rdata <= pd_cfg;
					`BIL_OFS_STAT: reg_rdata <= {3'h0, whole_mem, have_first, checksum_ok,
						debug_trap, boot_done};
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// header view
	// ----------------------------------------
	always_comb begin
		hsum = 32'h0;
		for (int i = 0; i < 12; i++) begin
			hsum = hsum + hdr[i];
		end
		pat_ok = hdr[0] == `BIL_PAT0 && hdr[1] == `BIL_PAT1;
		v0 = hdr[`BIL_HW_HSIZE] == `BIL_HDR_V0;
		// version 0 headers end before the checksum word
		hdr_ok = pat_ok && (v0 || hsum == hdr[`BIL_HW_HCSUM]);
		stored = v0 ? hdr[`BIL_HW_ISIZE] : hdr[`BIL_HW_FSIZE];
		dest = {hdr[`BIL_HW_DHI], hdr[`BIL_HW_DLO]};
		nb = (33'(base) + 33'(hdr[`BIL_HW_HSIZE]) + 33'(stored) + 33'h3) & ~33'h3;
		unique case (want_kind)
			WANT_FIRST: sel_hit = 1'b1;
			WANT_TYPE: sel_hit = !v0 && hdr[`BIL_HW_REV][15:8] == want_val;
			WANT_INDEX: sel_hit = idx == want_val;
			WANT_WHOLE: sel_hit = 1'b0;
		endcase
		eval_whole = want_kind == WANT_WHOLE || (!hdr_ok && !have_first);
		eval_take = !eval_whole && hdr_ok && (force_take || sel_hit);
	end

	// ----------------------------------------
	// search state machine
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state <= ST_CAPT;
			cap_cnt <= 2'h0;
			want_kind <= WANT_FIRST;
			want_val <= 8'h00;
			cbr_rd <= 1'b0;
			cbr_pend <= 1'b0;
			cbr_addr <= `BIL_CRAM_SEL_ADDR;
			base <= 20'h0;
			first_base <= 20'h0;
			idx <= 8'h01;
			have_first <= 1'b0;
			force_take <= 1'b0;
			whole_mem <= 1'b0;
			tgt <= 64'h0;
			img_csum <= 32'h0;
			img_size <= 32'h0;
			boot_done <= 1'b0;
			exec_addr <= 64'h0;
			debug_trap <= 1'b0;
			checksum_ok <= 1'b0;
			fw_type <= 8'h00;
		end else begin
			cbr_rd <= 1'b0;
			unique case (state)
				ST_CAPT: begin
					if (cap_cnt != `BIL_SYNC_CYCLES) begin
						cap_cnt <= cap_cnt + 2'h1;
					end else if (!jmp_s2[`BIL_JMP_DEBUG]) begin
						state <= ST_TRAP;
					end else if (jmp_s2[`BIL_JMP_BOOT_OPT]) begin
						want_kind <= WANT_FIRST;
						state <= ST_HDR;
					end else begin
						state <= ST_CRAM;
					end
				end
				ST_CRAM: begin
					if (!cbr_pend) begin
						cbr_rd <= 1'b1;
						cbr_pend <= 1'b1;
					end else if (cbr_rvalid) begin
						cbr_pend <= 1'b0;
						{want_kind, want_val} <= sel_decode(cbr_rdata);
						state <= ST_HDR;
					end
				end
				ST_HDR: begin
					if (hw_idx == `BIL_HDR_WORDS) begin
						state <= ST_EVAL;
					end
				end
				ST_EVAL: begin
					if (eval_whole || eval_take) begin
						state <= ST_LOAD;
						whole_mem <= eval_whole;
						tgt <= eval_whole ? 64'h0 : dest;
						img_csum <= hdr[`BIL_HW_ICSUM];
						img_size <= hdr[`BIL_HW_ISIZE];
						fw_type <= eval_whole ? 8'h00 : hdr[`BIL_HW_REV][15:8];
					end else if (!hdr_ok) begin
						// end of chain: go back to the first valid image
						base <= first_base;
						force_take <= 1'b1;
						state <= ST_HDR;
					end else begin
						if (!have_first) begin
							have_first <= 1'b1;
							first_base <= base;
						end
						idx <= idx + 8'h01;
						if (nb >= 33'(`BIL_MEM_BYTES)) begin
							base <= have_first ? first_base : base;
							force_take <= 1'b1;
						end else begin
							base <= nb[19:0];
						end
						state <= ST_HDR;
					end
				end
				ST_LOAD: begin
					if ((out_rem == 32'h0 || (in_rem == 21'h0 && rep_cnt == 8'h0)) && !rd_pend
						&& !load_valid && fifo_in_ready) begin
						state <= ST_DONE;
						boot_done <= 1'b1;
						exec_addr <= tgt;
						checksum_ok <= !whole_mem && csum_acc == img_csum;
					end
				end
				ST_DONE: begin
				end
				ST_TRAP: begin
					debug_trap <= 1'b1;
				end
				default: state <= ST_CAPT;
			endcase
		end
	end

	// ----------------------------------------
	// header word capture
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			hw_idx <= 4'h0;
		end else if (state != ST_HDR) begin
			hw_idx <= 4'h0;
		end else if (mem_rvalid) begin
			hdr[hw_idx] <= mem_rdata;
			hw_idx <= hw_idx + 4'h1;
		end
	end

	// ----------------------------------------
	// boot memory port
	// ----------------------------------------
	// loader owns bit 19 while reading; software's bank choice otherwise
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			mem_rd <= 1'b0;
			mem_addr <= 19'h0;
			mem_a19 <= 1'b0;
			rd_pend <= 1'b0;
			rd_addr <= 20'h0;
		end else begin
			mem_rd <= 1'b0;
			if (mem_rvalid) begin
				rd_pend <= 1'b0;
			end
			if (state == ST_EVAL) begin
				rd_addr <= eval_whole ? 20'h0 : base + hdr[`BIL_HW_HSIZE][19:0];
			end
			if (state == ST_HDR && !rd_pend && hw_idx != `BIL_HDR_WORDS) begin
				mem_rd <= 1'b1;
				{mem_a19, mem_addr} <= base + {14'h0, hw_idx, 2'h0};
				rd_pend <= 1'b1;
			end else if (state == ST_LOAD && !rd_pend && wcnt == 3'h0 && in_rem != 21'h0
				&& out_rem != 32'h0) begin
				mem_rd <= 1'b1;
				{mem_a19, mem_addr} <= rd_addr;
				rd_addr <= rd_addr + 20'h4;
				rd_pend <= 1'b1;
			end else if (state != ST_HDR && state != ST_LOAD) begin
				mem_a19 <= bank_sel;
			end
		end
	end

	// ----------------------------------------
	// byte source and run-length expander
	// ----------------------------------------
	// control byte: bit 7 clear copies n+1 literals, set repeats next byte n+1 times
	always_comb begin
		push = 1'b0;
		take = 1'b0;
		pdata = wbuf[7:0];
		if (state == ST_LOAD && out_rem != 32'h0 && fifo_in_ready) begin
			if (rep_cnt != 8'h0) begin
				push = 1'b1;
				pdata = rep_byte;
			end else if (wcnt != 3'h0 && in_rem != 21'h0) begin
				take = 1'b1;
				push = !decomp || (lit_cnt != 8'h0 && !rep_pend);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			{wbuf, wcnt, in_rem, out_rem, csum_acc, push_cnt} <= '0;
			{lit_cnt, rep_cnt, rep_len, rep_byte, rep_pend, decomp} <= '0;
			load_addr <= 64'h0;
		end else if (state == ST_EVAL) begin
			wcnt <= 3'h0;
			{lit_cnt, rep_cnt, rep_pend, csum_acc, push_cnt} <= '0;
			in_rem <= (eval_whole || stored >= 32'(`BIL_MEM_BYTES)) ? `BIL_MEM_BYTES : stored[20:0];
			out_rem <= eval_whole ? 32'(`BIL_MEM_BYTES) : hdr[`BIL_HW_ISIZE];
			decomp <= !eval_whole && hdr[`BIL_HW_DFLAG] != 32'h0;
			load_addr <= eval_whole ? 64'h0 : dest;
		end else begin
			if (state == ST_LOAD && mem_rvalid) begin
				wbuf <= mem_rdata;
				wcnt <= `BIL_WORD_BYTES;
			end
			if (take) begin
				wbuf <= {8'h00, wbuf[31:8]};
				wcnt <= wcnt - 3'h1;
				in_rem <= in_rem - 21'h1;
				csum_acc <= csum_acc + 32'(wbuf[7:0]);
				if (decomp && push) begin
					lit_cnt <= lit_cnt - 8'h1;
				end else if (decomp && rep_pend) begin
					rep_byte <= wbuf[7:0];
					rep_cnt <= rep_len;
					rep_pend <= 1'b0;
				end else if (decomp && wbuf[7]) begin
					rep_pend <= 1'b1;
					rep_len <= {1'b0, wbuf[6:0]} + 8'h1;
				end else if (decomp) begin
					lit_cnt <= {1'b0, wbuf[6:0]} + 8'h1;
				end
			end
			if (push && rep_cnt != 8'h0) begin
				rep_cnt <= rep_cnt - 8'h1;
			end
			if (push) begin
				out_rem <= out_rem - 32'h1;
				push_cnt <= push_cnt + 32'h1;
			end
			if (load_valid && load_ready) begin
				load_addr <= load_addr + 64'h1;
			end
		end
	end

	bil_fifo #(.W(8), .D(8)) u_fifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(pdata),
		.out_valid(load_valid),
		.out_ready(load_ready),
		.out_data(load_byte)
	);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_boot_lower;
		@(posedge ref_clk) disable iff (!resetn) $rose(resetn) |-> !bank_sel && !mem_a19;
	endproperty
	a_boot_lower: assert property (p_boot_lower) else $error("bank not lower after reset");

	property p_bank_set;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_wr && reg_addr == `BIL_OFS_BANK && reg_wdata[0] && state == ST_DONE) |=> ##1 mem_a19;
	endproperty
	a_bank_set: assert property (p_bank_set) else $error("bank write did not raise bit 19");

	property p_bank_hold;
		@(posedge ref_clk) disable iff (!resetn)
		(bank_sel && !(reg_wr && reg_addr == `BIL_OFS_BANK)) |=> bank_sel;
	endproperty
	a_bank_hold: assert property (p_bank_hold) else $error("upper bank dropped on its own");

	property p_trap;
		@(posedge ref_clk) disable iff (!resetn)
		(state == ST_CAPT && cap_cnt == `BIL_SYNC_CYCLES && !jmp_s2[`BIL_JMP_DEBUG])
		|=> state == ST_TRAP ##1 debug_trap;
	endproperty
	a_trap: assert property (p_trap) else $error("debug jumper did not trap");

	property p_first_when_out;
		@(posedge ref_clk) disable iff (!resetn)
		(state == ST_HDR && soft_cfg[`BIL_JMP_BOOT_OPT]) |-> want_kind == WANT_FIRST;
	endproperty
	a_first_when_out: assert property (p_first_when_out) else $error("jumper out not first");

	property p_cram_addr;
		@(posedge ref_clk) disable iff (!resetn)
		cbr_rd |-> cbr_addr == `BIL_CRAM_SEL_ADDR && state == ST_CRAM;
	endproperty
	a_cram_addr: assert property (p_cram_addr) else $error("clock ram read wrong byte");

	property p_no_valid_whole;
		@(posedge ref_clk) disable iff (!resetn)
		(state == ST_EVAL && !hdr_ok && !have_first)
		|=> state == ST_LOAD && whole_mem && load_addr == 64'h0;
	endproperty
	a_no_valid_whole: assert property (p_no_valid_whole) else $error("no header not whole load");

	property p_size_bound;
		@(posedge ref_clk) disable iff (!resetn)
		(state == ST_LOAD && !whole_mem) |-> push_cnt <= img_size;
	endproperty
	a_size_bound: assert property (p_size_bound) else $error("loaded past image size");

	property p_exec_target;
		@(posedge ref_clk) disable iff (!resetn)
		(state == ST_LOAD ##1 state == ST_DONE) |-> boot_done && exec_addr == tgt
		&& (!whole_mem || exec_addr == 64'h0);
	endproperty
	a_exec_target: assert property (p_exec_target) else $error("wrong execution address");

	c_trap: cover property (@(posedge ref_clk) disable iff (!resetn) state == ST_TRAP);
	c_decomp_done: cover property (@(posedge ref_clk) disable iff (!resetn)
		decomp && state == ST_DONE);
	// a whole-memory load never finishes in a short run, so its start is covered
	c_whole: cover property (@(posedge ref_clk) disable iff (!resetn)
		whole_mem && state == ST_LOAD && load_valid);
	c_bank_up: cover property (@(posedge ref_clk) disable iff (!resetn) mem_a19 && boot_done);
endmodule

`default_nettype wire

/* File: rtl/bil_pkg.sv */
// types of the boot image loader: loader states and selection kinds
// needs nothing from bil_consts.svh; it includes no file
package bil_pkg;
	// gray codes along capture, clock ram read, header read, eval, load, done
	typedef enum logic [2:0] {
		ST_CAPT = 3'h0,
		ST_CRAM = 3'h1,
		ST_HDR = 3'h3,
		ST_EVAL = 3'h2,
		ST_LOAD = 3'h6,
		ST_DONE = 3'h7,
		ST_TRAP = 3'h5
	} bil_state_t;

	typedef enum logic [1:0] {
		WANT_FIRST = 2'h0,
		WANT_TYPE = 2'h1,
		WANT_INDEX = 2'h2,
		WANT_WHOLE = 2'h3
	} bil_want_t;
endpackage

/* File: test/bil_flash_model.sv */
// bench model of flash boot memory and clock-backed ram
// assumes one outstanding read, requested by one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module bil_flash_model (
	// clock
	input wire logic ref_clk,
	// boot memory
	input wire logic mem_rd,
	input wire logic [18:0] mem_addr,
	input wire logic mem_a19,
	output logic [31:0] mem_rdata,
	output logic mem_rvalid,
	// clock ram
	input wire logic cbr_rd,
	input wire logic [5:0] cbr_addr,
	output logic [7:0] cbr_rdata,
	output logic cbr_rvalid
);
	logic [31:0] img [16];
	logic [7:0] sel_code = 8'h0;
	logic [1:0] wait_n = 2'h0;
	logic [31:0] pend = 32'h0;
	logic busy = 1'b0;
	initial begin
		mem_rdata = 32'h0;
		cbr_rdata = 8'h0;
	end
	// answer after 1 to 4 cycles; idle data toggles so stale values never pass
	always @(posedge ref_clk) begin
		mem_rvalid <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_rd) begin
			busy <= 1'b1;
			wait_n <= mem_addr[3:2];
			// upper half holds erased flash only
			pend <= (!mem_a19 && mem_addr < 19'h40) ? img[mem_addr[5:2]] : 32'hffffffff;
		end else if (busy && wait_n != 2'h0) begin
			wait_n <= wait_n - 2'h1;
		end else if (busy) begin
			busy <= 1'b0;
			mem_rvalid <= 1'b1;
			mem_rdata <= pend;
		end
	end
	// selection byte sits at one location only
	always @(posedge ref_clk) begin
		cbr_rvalid <= cbr_rd;
		cbr_rdata <= (cbr_rd && cbr_addr == 6'h3f) ? sel_code : ~cbr_rdata;
	end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench of the boot image loader
// assumes bil_loader and bil_flash_model compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic ref_clk, resetn, reg_wr, reg_rd, mem_rd, mem_a19, mem_rvalid, cbr_rd, cbr_rvalid;
	logic load_valid, load_ready, boot_done, debug_trap, checksum_ok, cache_cfg_reserved;
	logic [7:0] reg_wdata, reg_rdata, cbr_rdata, soft_config_bit, presence_detect;
	logic [7:0] load_byte, fw_type, rd;
	logic [11:0] reg_addr;
	logic [18:0] mem_addr;
	logic [31:0] mem_rdata;
	logic [5:0] cbr_addr;
	logic [63:0] load_addr, exec_addr, dest;
	logic [4:0] cache_period_ns;
	logic [13:0] cache_size_kb;
	logic [15:0] lf = 16'h438b;
	int n_fail = 0;
	int compares = 0;
	int k, nb;
	logic [4:0] per_tab [8] = '{5'h0, 5'h6, 5'h8, 5'ha, 5'hc, 5'hf, 5'h0, 5'h0};
	logic [13:0] siz_tab [8] = '{14'h0, 14'h200, 14'h400, 14'h800, 14'h1000, 14'h2000, 14'h0, 14'h0};
	logic [7:0] code_tab [4] = '{8'h02, 8'h03, 8'h81, 8'h00};
	bil_loader uut (.ref_clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.mem_rd, .mem_addr, .mem_a19, .mem_rdata, .mem_rvalid, .cbr_rd, .cbr_addr, .cbr_rdata,
		.cbr_rvalid, .soft_config_bit, .presence_detect, .load_valid, .load_addr, .load_byte,
		.load_ready, .boot_done, .exec_addr, .debug_trap, .checksum_ok, .fw_type,
		.cache_period_ns, .cache_size_kb, .cache_cfg_reserved);
	bil_flash_model fm (.ref_clk, .mem_rd, .mem_addr, .mem_a19, .mem_rdata, .mem_rvalid,
		.cbr_rd, .cbr_addr, .cbr_rdata, .cbr_rvalid);
	// -----------------------------
	// helpers
	// -----------------------------
	function automatic logic [15:0] step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// byte j of boot memory; past the model's image it reads erased
	function automatic logic [7:0] bb(input int j);
		return j < 64 ? fm.img[j / 4][8 * (j % 4) +: 8] : 8'hff;
	endfunction
	// expected output byte j: whole memory, expanded run of four then literals, or body
	function automatic logic [7:0] ob(input int j, input bit wh);
		if (wh) return bb(j);
		if (fm.img[5] != 32'h0) return bb(j < 4 ? 53 : 51 + j);
		return bb(52 + j);
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	// one register access; read data lands one cycle after the strobe
	task automatic reg_op(input logic wr, input logic [11:0] a, input logic [7:0] wd);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= wd;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		rd = reg_rdata;
	endtask
	// header with both checksums, two random body words, dead header after
	task automatic build_img(input bit cz, input bit bad);
		logic [31:0] s;
		s = 32'h0;
		fm.img = '{32'h5a5ac3c3, 32'ha5a53c3c, 32'h34, 32'h0, 32'h8, {31'h0, cz}, {lf, 16'h0}, 32'h1,
			32'h0201, cz ? 32'h7 : 32'h8, 32'h0, 32'h0, 32'h0, {lf, ~lf}, {~lf, step(lf)}, 32'h0};
		// compressed body: run of four, then four literals, seven stored bytes
		if (cz) begin
			fm.img[13] = {lf[15:8], 8'h03, lf[7:0], 8'h83};
			fm.img[14] = {8'h00, ~lf, lf[7:0]};
		end
		for (int j = 0; j < fm.img[9]; j++) s += bb(52 + j);
		fm.img[3] = s;
		s = 32'h0;
		for (int i = 0; i < 12; i++) s += fm.img[i];
		fm.img[12] = s ^ {31'h0, bad};
		dest = {fm.img[7], fm.img[6]};
	endtask
	// -----------------------------
	// one boot run
	// -----------------------------
	task automatic boot(input logic [7:0] jmp, input logic [7:0] code, input bit cz, input bit bad);
		logic [7:0] pd;
		bit wh;
		pd = lf[15:8];
		wh = bad && jmp[6];
		build_img(cz, bad);
		fm.sel_code = code;
		resetn <= 1'b0;
		soft_config_bit <= jmp;
		presence_detect <= pd;
		load_ready <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		chk(mem_a19, 1'b0);
		nb = 0;
		// a whole-memory load runs far too long, so only its start is followed
		for (k = 0; k < 3000 && boot_done !== 1'b1 && debug_trap !== 1'b1
			&& (!wh || nb < 72); k++) begin
			// handshake seen settled, half a cycle before the edge that takes it
			@(negedge ref_clk);
			if (load_valid === 1'b1 && load_ready === 1'b1) begin
				chk(load_byte, ob(nb, wh));
				chk(load_addr, (wh ? 64'h0 : dest) + nb);
				nb++;
			end
			@(posedge ref_clk);
			load_ready <= lf[0];
			lf = step(lf);
		end
		repeat (2) @(posedge ref_clk);
		chk(debug_trap, !jmp[6]);
		chk(boot_done, jmp[6] && !wh);
		chk(nb, jmp[6] ? (wh ? 72 : 8) : 0);
		if (jmp[6] && !wh) begin
			chk(exec_addr, dest);
			chk(fw_type, 8'h02);
			chk(checksum_ok, 1'b1);
		end
		chk(cache_period_ns, per_tab[jmp[5:3]]);
		chk(cache_size_kb, siz_tab[jmp[2:0]]);
		chk(cache_cfg_reserved, per_tab[jmp[5:3]] == 5'h0 || jmp[2:0] > 3'h5);
		reg_op(1'b0, 12'h801, 8'h0);
		chk(rd, jmp);
		reg_op(1'b0, 12'h802, 8'h0);
		chk(rd, pd);
		// status: whole, passed-over valid header, checksum, trap, done
		reg_op(1'b0, 12'h803, 8'h0);
		chk(rd, jmp[6] ? {3'h0, wh, !wh && !jmp[7] && code == 8'h00, !wh, 1'b0, !wh}
			: 8'h02);
		reg_op(1'b0, 12'h800, 8'h0);
		chk(rd, 8'h0); // write-only place reads back zero
		reg_op(1'b1, 12'h800, 8'h1);
		repeat (2) @(posedge ref_clk);
		// a load in progress keeps the loader's own bit
		chk(mem_a19, !wh);
		reg_op(1'b1, 12'h800, 8'h0);
		repeat (2) @(posedge ref_clk);
		chk(mem_a19, 1'b0);
		reg_op(1'b1, 12'h800, 8'h1);
	endtask
	task automatic complete_run();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// random jumpers, codes from a fixed table; third run traps, second, fourth and sixth runs compressed, last header broken
	initial begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 12'h0;
		reg_wdata = 8'h0;
		soft_config_bit = 8'hff;
		presence_detect = 8'h0;
		load_ready = 1'b0;
		for (int t = 0; t < 7; t++) begin
			boot({lf[7], t != 2, lf[5:0]}, code_tab[t % 4], t[0], t == 6);
			$display("test %0d done", t);
		end
		complete_run();
	end
	initial begin
		#2000000;
		n_fail++;
		complete_run();
	end
endmodule
`default_nettype wire
